// *** src/tsc_serial_ctrl.sv ***
// serial control, conversion framing and pen interrupt of the touch converter
`timescale 1ns/1ps

module tsc_serial_ctrl (
	input  wire logic                   clk,
	input  wire logic                   nrst,
	input  wire logic                   cs_n,
	input  wire logic                   serial_clk,
	input  wire logic                   serial_in,
	input  wire logic                   xplus_sense,
	input  wire logic [tsc_pkg::RES_W-1:0] sar_result,
	output logic                        serial_out,
	output logic                        serial_out_oe,
	output logic                        busy,
	output logic                        busy_oe,
	output logic                        pen_touch_irq_n,
	output logic [2:0]                  channel_sel,
	output logic                        res_8bit,
	output logic                        ref_mode_sel,
	output logic                        adc_powerdown_sel,
	output logic                        ref_powerdown_sel,
	output logic                        adc_powered,
	output logic                        ref_powered,
	output logic                        sample_start,
	output logic                        panel_drv_on,
	output logic                        y_minus_on,
	output logic                        xplus_pullup_en
);
	import tsc_pkg::*;

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [3:0] pin_sync;
	logic [3:0] pin_prev;

	tsc_pin_sync #(
		.WIDTH   (4),
		.RST_VAL (4'h9)
	) u_sync (
		.clk       (clk),
		.nrst      (nrst),
		.pin_in    ({xplus_sense, serial_in, serial_clk, cs_n}),
		.sync_out  (pin_sync),
		.sync_prev (pin_prev)
	);

	logic cs_off;
	logic sclk_rise;
	logic sclk_fall;
	logic din;
	logic xplus_lvl;

	assign cs_off    = pin_sync[0];
	assign sclk_rise = pin_sync[1] & ~pin_prev[1] & ~cs_off;
	assign sclk_fall = ~pin_sync[1] & pin_prev[1] & ~cs_off;
	assign din       = pin_sync[2];
	assign xplus_lvl = pin_sync[3];

	// ----------------------------------------------------------------
	// control byte receiver
	// ----------------------------------------------------------------
	logic                  rx_active_reg;
	logic                  rx_active_next;
	logic [CTRL_CNT_W-1:0] rx_cnt_reg;
	logic [CTRL_CNT_W-1:0] rx_cnt_next;
	logic [CTRL_BITS-2:0]  rx_sh_reg;
	logic [CTRL_BITS-2:0]  rx_sh_next;
	logic                  cfg_take;
	logic                  pd_take;

	assign cfg_take = sclk_rise & rx_active_reg & (rx_cnt_reg == CNT_REF_MODE);
	assign pd_take  = sclk_rise & rx_active_reg & (rx_cnt_reg == CNT_PD0);

	always_comb begin
		rx_active_next = rx_active_reg;
		rx_cnt_next    = rx_cnt_reg;
		rx_sh_next     = rx_sh_reg;
		if (cs_off) begin
			rx_active_next = 1'b0;
			rx_cnt_next    = '0;
		end else if (sclk_rise) begin
			if (!rx_active_reg) begin
				if (din) begin
					rx_active_next = 1'b1;
					rx_cnt_next    = '0;
				end
			end else begin
				rx_sh_next  = {rx_sh_reg[CTRL_BITS-3:0], din};
				rx_cnt_next = rx_cnt_reg + 1'b1;
				if (rx_cnt_reg == CNT_PD0) begin
					rx_active_next = 1'b0;
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			rx_active_reg <= 1'b0;
			rx_cnt_reg    <= '0;
			rx_sh_reg     <= '0;
		end else begin
			rx_active_reg <= rx_active_next;
			rx_cnt_reg    <= rx_cnt_next;
			rx_sh_reg     <= rx_sh_next;
		end
	end

	// ----------------------------------------------------------------
	// conversion sequencer and power state
	// ----------------------------------------------------------------
	tsc_conv_type           st_reg;
	tsc_conv_type           st_next;
	logic [2:0]             chan_reg;
	logic [2:0]             chan_next;
	logic                   res8_reg;
	logic                   res8_next;
	logic                   sgl_reg;
	logic                   sgl_next;
	logic                   pd0_reg;
	logic                   pd0_next;
	logic                   pd1_reg;
	logic                   pd1_next;
	logic                   pd_ready_reg;
	logic                   pd_ready_next;
	logic                   ref_on_reg;
	logic                   ref_on_next;
	logic                   pen_en_reg;
	logic                   pen_en_next;
	logic [BIT_CNT_W-1:0]   bit_reg;
	logic [BIT_CNT_W-1:0]   bit_next;
	logic [RES_W-1:0]       res_reg;
	logic [RES_W-1:0]       res_next;
	logic                   dout_reg;
	logic                   dout_next;
	logic                   start_reg;
	logic                   start_next;
	logic [1:0]             strap_cnt_reg;
	logic [1:0]             strap_cnt_next;

	always_comb begin
		st_next         = st_reg;
		chan_next       = chan_reg;
		res8_next       = res8_reg;
		sgl_next        = sgl_reg;
		pd0_next        = pd0_reg;
		pd1_next        = pd1_reg;
		pd_ready_next   = pd_ready_reg;
		ref_on_next     = ref_on_reg;
		pen_en_next     = pen_en_reg;
		bit_next        = bit_reg;
		res_next        = res_reg;
		dout_next       = dout_reg;
		start_next      = 1'b0;
		strap_cnt_next  = (strap_cnt_reg == 2'h3) ? strap_cnt_reg : strap_cnt_reg + 2'h1;
		// power-up strap, looked at once the synchroniser holds real pin levels
		if ((strap_cnt_reg == 2'(SYNC_STAGES)) && !cs_off && pin_sync[1]) begin
			pd0_next    = 1'b0;
			pen_en_next = 1'b1;
		end
		if (cs_off) begin
			st_next       = CONV_IDLE;
			pd_ready_next = 1'b0;
			dout_next     = 1'b0;
			pen_en_next   = ~pd0_reg;
		end else begin
			if (cfg_take) begin
				// new byte takes over any result still shifting
				chan_next     = rx_sh_reg[CHAN_MSB_POS:CHAN_LSB_POS];
				res8_next     = rx_sh_reg[MODE_POS];
				sgl_next      = din;
				st_next       = CONV_ACQ;
				pd_ready_next = 1'b0;
				pen_en_next   = 1'b0;
			end
			if (pd_take) begin
				pd1_next      = rx_sh_reg[PD1_POS];
				pd0_next      = din;
				pd_ready_next = 1'b1;
			end
			if (sclk_fall) begin
				unique case (st_reg)
					CONV_IDLE: begin
						dout_next = 1'b0;
					end
					CONV_ACQ: begin
						if (pd_ready_reg) begin
							st_next     = CONV_BUSY;
							start_next  = 1'b1;
							ref_on_next = pd1_reg;
							dout_next   = 1'b0;
						end
					end
					CONV_BUSY: begin
						st_next   = CONV_SHIFT;
						res_next  = res8_reg ? {sar_result[RES_W-1:RES_W-RES_LO_W],
							{(RES_W-RES_LO_W){1'b0}}} : sar_result;
						bit_next  = res8_reg ? MSB_IDX_8 : MSB_IDX_12;
						dout_next = sar_result[RES_W-1];
					end
					CONV_SHIFT: begin
						dout_next = res_reg[RES_W-1-(res8_reg ? MSB_IDX_8 : MSB_IDX_12)
							+ bit_reg - 1'b1];
						bit_next  = bit_reg - 1'b1;
						if (bit_reg == 4'h1) begin
							st_next     = CONV_IDLE;
							pen_en_next = ~pd0_reg;
						end
					end
				endcase
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			st_reg         <= CONV_IDLE;
			chan_reg       <= RST_CHANNEL;
			res8_reg       <= RST_RES_8BIT;
			sgl_reg        <= RST_REF_MODE;
			pd0_reg        <= RST_ADC_PD_SEL;
			pd1_reg        <= RST_REF_PD_SEL;
			pd_ready_reg   <= 1'b0;
			ref_on_reg     <= RST_REF_ON;
			pen_en_reg     <= 1'b0;
			bit_reg        <= '0;
			res_reg        <= '0;
			dout_reg       <= 1'b0;
			start_reg      <= 1'b0;
			strap_cnt_reg  <= '0;
		end else begin
			st_reg         <= st_next;
			chan_reg       <= chan_next;
			res8_reg       <= res8_next;
			sgl_reg        <= sgl_next;
			pd0_reg        <= pd0_next;
			pd1_reg        <= pd1_next;
			pd_ready_reg   <= pd_ready_next;
			ref_on_reg     <= ref_on_next;
			pen_en_reg     <= pen_en_next;
			bit_reg        <= bit_next;
			res_reg        <= res_next;
			dout_reg       <= dout_next;
			start_reg      <= start_next;
			strap_cnt_reg  <= strap_cnt_next;
		end
	end

	// ----------------------------------------------------------------
	// touch drivers, pen interrupt and outputs
	// ----------------------------------------------------------------
	logic touch_ch;
	logic converting;

	assign touch_ch   = (chan_reg == CH_X_POS) | (chan_reg == CH_Y_POS)
		| (chan_reg == CH_Z1_POS) | (chan_reg == CH_Z2_POS);
	assign converting = (st_reg == CONV_BUSY) | (st_reg == CONV_SHIFT);

	always_comb begin
		panel_drv_on = 1'b0;
		if (touch_ch && !cs_off) begin
			if (st_reg == CONV_ACQ) begin
				panel_drv_on = 1'b1;
			end else if (converting && !sgl_reg) begin
				panel_drv_on = 1'b1;
			end
		end
		if (pen_en_reg) begin
			pen_touch_irq_n = xplus_lvl;
		end else begin
			pen_touch_irq_n = ~touch_ch;
		end
	end

	assign y_minus_on        = pen_en_reg;
	assign xplus_pullup_en   = pen_en_reg;
	assign adc_powered       = pd0_reg | (~cs_off & (st_reg != CONV_IDLE));
	assign ref_powered       = ref_on_reg;
	assign busy              = (st_reg == CONV_BUSY) & ~cs_off;
	assign busy_oe           = ~cs_off;
	assign serial_out        = dout_reg;
	assign serial_out_oe     = ~cs_off;
	assign sample_start      = start_reg;
	assign channel_sel       = chan_reg;
	assign res_8bit          = res8_reg;
	assign ref_mode_sel      = sgl_reg;
	assign adc_powerdown_sel = pd0_reg;
	assign ref_powerdown_sel = pd1_reg;

endmodule // tsc_serial_ctrl

// *** src/tsc_pkg.sv ***
// shared constants of the touch converter serial control block
package tsc_pkg;

	// ----------------------------------------------------------------
	// control byte layout, bits that follow the start bit
	// ----------------------------------------------------------------
	localparam int unsigned CTRL_BITS      = 7;
	localparam int unsigned CTRL_CNT_W     = 3;
	localparam logic [2:0]  CNT_REF_MODE   = 3'h4;
	localparam logic [2:0]  CNT_PD0        = 3'h6;
	localparam int unsigned CHAN_MSB_POS   = 3;
	localparam int unsigned CHAN_LSB_POS   = 1;
	localparam int unsigned MODE_POS       = 0;
	localparam int unsigned PD1_POS        = 0;

	// ----------------------------------------------------------------
	// result widths
	// ----------------------------------------------------------------
	localparam int unsigned RES_W          = 12;
	localparam int unsigned RES_LO_W       = 8;
	localparam int unsigned BIT_CNT_W      = 4;
	localparam logic [3:0]  MSB_IDX_12     = 4'hb;
	localparam logic [3:0]  MSB_IDX_8      = 4'h7;

	// ----------------------------------------------------------------
	// channel codes of the position and pressure measurements
	// ----------------------------------------------------------------
	localparam logic [2:0]  CH_Y_POS       = 3'h1;
	localparam logic [2:0]  CH_Z1_POS      = 3'h3;
	localparam logic [2:0]  CH_Z2_POS      = 3'h4;
	localparam logic [2:0]  CH_X_POS       = 3'h5;

	// ----------------------------------------------------------------
	// reset values and synchroniser depth
	// ----------------------------------------------------------------
	localparam logic [2:0]  RST_CHANNEL    = 3'h0;
	localparam logic        RST_RES_8BIT   = 1'b0;
	localparam logic        RST_REF_MODE   = 1'b1;
	localparam logic        RST_ADC_PD_SEL = 1'b1;
	localparam logic        RST_REF_PD_SEL = 1'b0;
	localparam logic        RST_REF_ON     = 1'b0;
	localparam int unsigned SYNC_STAGES    = 2;

	typedef enum logic [1:0] {
		CONV_IDLE  = 2'b00,
		CONV_ACQ   = 2'b01,
		CONV_BUSY  = 2'b10,
		CONV_SHIFT = 2'b11
	} tsc_conv_type;

endpackage : tsc_pkg

// *** src/tsc_pin_sync.sv ***
// two-stage pin synchroniser with a delayed copy for edge detection
`timescale 1ns/1ps

module tsc_pin_sync #(
	parameter int unsigned WIDTH = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input  wire logic             clk,
	input  wire logic             nrst,
	input  wire logic [WIDTH-1:0] pin_in,
	output logic      [WIDTH-1:0] sync_out,
	output logic      [WIDTH-1:0] sync_prev
);

	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] meta_next;
	logic [WIDTH-1:0] sync_reg;
	logic [WIDTH-1:0] sync_next;
	logic [WIDTH-1:0] prev_reg;
	logic [WIDTH-1:0] prev_next;

	always_comb begin
		meta_next = pin_in;
		sync_next = meta_reg;
		prev_next = sync_reg;
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			meta_reg <= RST_VAL;
			sync_reg <= RST_VAL;
			prev_reg <= RST_VAL;
		end else begin
			meta_reg <= meta_next;
			sync_reg <= sync_next;
			prev_reg <= prev_next;
		end
	end

	assign sync_out  = sync_reg;
	assign sync_prev = prev_reg;

endmodule // tsc_pin_sync

// *** testbench/tsc_serial_ctrl_props.sv ***
// assertions on pen interrupt, power and abort behaviour of the serial control block
`timescale 1ns/1ps

module tsc_serial_ctrl_props
	import tsc_pkg::*;
(
	input wire logic       clk,
	input wire logic       nrst,
	input wire logic       cs_n,
	input wire logic       busy,
	input wire logic       busy_oe,
	input wire logic       serial_out,
	input wire logic       serial_out_oe,
	input wire logic       pen_touch_irq_n,
	input wire logic [2:0] channel_sel,
	input wire logic       ref_mode_sel,
	input wire logic       adc_powerdown_sel,
	input wire logic       ref_powerdown_sel,
	input wire logic       adc_powered,
	input wire logic       ref_powered,
	input wire logic       panel_drv_on,
	input wire logic       xplus_pullup_en,
	input wire logic       sample_start,
	input wire logic       y_minus_on
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);

	logic touch;
	assign touch = channel_sel inside {CH_Y_POS, CH_Z1_POS, CH_Z2_POS, CH_X_POS};

	// chip select high long enough to pass the synchroniser
	sequence s_cs_idle;
		cs_n [*6];
	endsequence

	a_cs_abort: assert property (s_cs_idle |-> !busy && !serial_out && !serial_out_oe && !busy_oe)
		else $error("conversion not abandoned with chip select high");
	a_pos_irq_low: assert property ((!xplus_pullup_en && touch) [*2] |-> !pen_touch_irq_n)
		else $error("pen irq not low during position measurement");
	a_aux_irq_high: assert property ((!xplus_pullup_en && !touch) [*2] |-> pen_touch_irq_n)
		else $error("pen irq not high during auxiliary measurement");
	a_pd_sel_pen: assert property (adc_powerdown_sel |-> !xplus_pullup_en)
		else $error("pen detection enabled with full power select");
	a_busy_powered: assert property (busy |-> adc_powered)
		else $error("converter not powered while busy");
	a_full_power: assert property (adc_powerdown_sel |-> adc_powered)
		else $error("converter off in full power mode");
	a_auto_pd: assert property ((cs_n && !adc_powerdown_sel) [*6] |-> !adc_powered)
		else $error("converter still powered after chip select high");
	a_ref_latch: assert property ($rose(busy) |-> ##[0:2] (ref_powered == ref_powerdown_sel))
		else $error("reference power not latched at busy rise");
	a_ref_hold: assert property (s_cs_idle |=> $stable(ref_powered))
		else $error("reference power changed with chip select high");
	a_panel_se: assert property (busy && ref_mode_sel |-> !panel_drv_on)
		else $error("panel driven during single-ended conversion");
	a_panel_diff: assert property (busy && !ref_mode_sel && touch |-> panel_drv_on)
		else $error("panel released during differential conversion");
	a_start_pulse: assert property ($rose(busy) |-> sample_start ##1 !sample_start)
		else $error("sample start not a single pulse at busy rise");
	a_ymin_pd: assert property ((cs_n && !adc_powerdown_sel) [*6] |-> y_minus_on)
		else $error("y-minus driver off in auto power-down");
endmodule // tsc_serial_ctrl_props

bind tsc_serial_ctrl tsc_serial_ctrl_props u_props (
	.clk               (clk),
	.nrst              (nrst),
	.cs_n              (cs_n),
	.busy              (busy),
	.busy_oe           (busy_oe),
	.serial_out        (serial_out),
	.serial_out_oe     (serial_out_oe),
	.pen_touch_irq_n   (pen_touch_irq_n),
	.channel_sel       (channel_sel),
	.ref_mode_sel      (ref_mode_sel),
	.adc_powerdown_sel (adc_powerdown_sel),
	.ref_powerdown_sel (ref_powerdown_sel),
	.adc_powered       (adc_powered),
	.ref_powered       (ref_powered),
	.panel_drv_on      (panel_drv_on),
	.xplus_pullup_en   (xplus_pullup_en),
	.sample_start      (sample_start),
	.y_minus_on        (y_minus_on)
);

// *** testbench/tsc_host_model.sv ***
// host serial master model driving chip select, serial clock and data
`timescale 1ns/1ps

module tsc_host_model (
	input  wire logic clk,
	output logic      cs_n,
	output logic      serial_clk,
	output logic      serial_in,
	input  wire logic serial_out
);
	// each serial clock phase spans six system clocks
	localparam int HALF = 6;

	initial begin
		cs_n = 1'b1;
		serial_clk = 1'b0;
		serial_in = 1'b0;
	end

	task automatic wait_clk(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic select(input logic sel_n);
		wait_clk(1);
		cs_n = sel_n;
		if (sel_n) begin
			serial_in = ~serial_in;
		end
		wait_clk(HALF);
	endtask

	// power-up strap: selected with the serial clock held high
	task automatic strap();
		cs_n = 1'b0;
		serial_clk = 1'b1;
		serial_in = 1'b0;
	endtask

	// n serial clocks, data msb first, result sampled at each rising edge
	task automatic xfer(input int n, input logic [23:0] tx, output logic [23:0] rx);
		rx = '0;
		for (int i = 0; i < n; i++) begin
			serial_in = tx[23-i];
			wait_clk(HALF);
			serial_clk = 1'b1;
			rx = {rx[22:0], serial_out};
			wait_clk(HALF);
			serial_clk = 1'b0;
		end
	endtask
endmodule // tsc_host_model

// *** testbench/tsc_serial_ctrl_tb_top.sv ***
// self-checking testbench of the touch converter serial control block
`timescale 1ns/1ps

module tsc_serial_ctrl_tb_top;
	import tsc_pkg::*;

	logic             clk = 1'b0;
	logic             nrst = 1'b0;
	logic             xplus_sense = 1'b1;
	logic [RES_W-1:0] sar_result = 12'ha5c;
	logic             cs_n, serial_clk, serial_in, serial_out, serial_out_oe;
	logic             busy, busy_oe, pen_touch_irq_n, res_8bit, ref_mode_sel;
	logic [2:0]       channel_sel;
	logic             adc_powerdown_sel, ref_powerdown_sel, adc_powered, ref_powered;
	logic             sample_start, panel_drv_on, y_minus_on, xplus_pullup_en;
	logic [23:0]      rx, ry, rz;
	int               num_errors = 0;
	int               num_checks = 0;

	always #2.5 clk = ~clk;

	tsc_serial_ctrl DUT (
		.clk               (clk),
		.nrst              (nrst),
		.cs_n              (cs_n),
		.serial_clk        (serial_clk),
		.serial_in         (serial_in),
		.xplus_sense       (xplus_sense),
		.sar_result        (sar_result),
		.serial_out        (serial_out),
		.serial_out_oe     (serial_out_oe),
		.busy              (busy),
		.busy_oe           (busy_oe),
		.pen_touch_irq_n   (pen_touch_irq_n),
		.channel_sel       (channel_sel),
		.res_8bit          (res_8bit),
		.ref_mode_sel      (ref_mode_sel),
		.adc_powerdown_sel (adc_powerdown_sel),
		.ref_powerdown_sel (ref_powerdown_sel),
		.adc_powered       (adc_powered),
		.ref_powered       (ref_powered),
		.sample_start      (sample_start),
		.panel_drv_on      (panel_drv_on),
		.y_minus_on        (y_minus_on),
		.xplus_pullup_en   (xplus_pullup_en)
	);
	tsc_host_model host (
		.clk        (clk),
		.cs_n       (cs_n),
		.serial_clk (serial_clk),
		.serial_in  (serial_in),
		.serial_out (serial_out)
	);

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
			num_errors++;
		end
	endtask

	task automatic done(input string name);
		$display("test %s done", name);
	endtask

	task automatic complete_run;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// --------------------------------
	// tests
	// --------------------------------
	initial begin
		repeat (2) @(posedge clk);
		#1 nrst = 1'b1;
		host.wait_clk(3);
		chk({adc_powered, adc_powerdown_sel}, 2'h3);
		chk(pen_touch_irq_n, 1'b1);
		done("reset");
		host.select(1'b0);
		host.xfer(24, {8'hd0, 16'h0}, rx);
		chk(rx[14:3], 12'ha5c);
		chk({channel_sel, res_8bit, ref_mode_sel}, 5'h14);
		xplus_sense = 1'b0;
		host.wait_clk(4);
		chk({pen_touch_irq_n, adc_powered}, 2'h0);
		xplus_sense = 1'b1;
		host.wait_clk(4);
		chk(pen_touch_irq_n, 1'b1);
		chk({y_minus_on, xplus_pullup_en}, 2'h3);
		done("conv12");
		host.xfer(24, {8'hd0, 8'h00, 8'h90}, rx);
		sar_result = 12'h3c1;
		host.xfer(16, 24'h0, ry);
		chk(rx[14:3], 12'ha5c);
		chk(ry[14:3], 12'h3c1);
		chk(channel_sel, 3'h1);
		done("overlap16");
		sar_result = 12'h7e2;
		host.xfer(15, {8'hd0, 16'h0}, rx);
		sar_result = 12'h18f;
		host.xfer(15, {8'h90, 16'h0}, ry);
		host.xfer(15, 24'h0, rz);
		chk({rx[5:0], ry[14:9]}, 12'h7e2);
		chk({ry[5:0], rz[14:9]}, 12'h18f);
		done("overlap15");
		host.xfer(24, {8'haf, 16'h0}, rx);
		chk(rx[14:3], {sar_result[11:4], 4'h0});
		xplus_sense = 1'b0;
		host.wait_clk(4);
		chk({pen_touch_irq_n, ref_powered, adc_powered}, 3'h7);
		xplus_sense = 1'b1;
		done("conv8");
		host.xfer(12, {8'hd2, 16'h0}, rx);
		chk({xplus_pullup_en, pen_touch_irq_n}, 2'h0);
		host.select(1'b1);
		host.wait_clk(4);
		chk({serial_out_oe, busy_oe, busy, serial_out, ref_powered, adc_powered}, 6'h02);
		host.select(1'b0);
		host.xfer(24, {8'hd0, 16'h0}, rx);
		chk(rx[14:3], sar_result);
		host.select(1'b1);
		host.wait_clk(4);
		chk(ref_powered, 1'b0);
		done("abort");
		nrst = 1'b0;
		host.strap();
		repeat (2) @(posedge clk);
		#1 nrst = 1'b1;
		xplus_sense = 1'b0;
		host.wait_clk(4);
		chk({adc_powerdown_sel, adc_powered, y_minus_on, pen_touch_irq_n}, 4'h2);
		done("strap");
		complete_run();
	end

	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		complete_run();
	end
endmodule // tsc_serial_ctrl_tb_top
